// ===== shared/bsr_pkg.sv
/*
 Package for the boot select and reset control block: boot codes, states, counts.
 Assumes one 10 MHz system clock and a synchronous active-low power-up reset.
*/
package bsr_pkg;

  typedef enum logic [2:0] {
    BSR_BOOT_SPI_SLAVE,
    BSR_BOOT_SPI_MASTER,
    BSR_BOOT_PARALLEL,
    BSR_BOOT_ROM,
    BSR_BOOT_RESERVED
  } bsr_boot_t;

  typedef enum logic [2:0] {
    BSR_ST_SAMPLE,
    BSR_ST_LOAD,
    BSR_ST_RUN,
    BSR_ST_RESET,
    BSR_ST_HALT
  } bsr_state_t;

  localparam logic [2:0] BSR_C3_SPI_SLAVE = 3'h0;
  localparam logic [2:0] BSR_C3_SPI_MASTER = 3'h1;
  localparam logic [2:0] BSR_C3_PARALLEL = 3'h2;
  localparam logic [2:0] BSR_C3_ROM = 3'h3;
  localparam logic [1:0] BSR_C2_SPI_SLAVE = 2'h0;
  localparam logic [1:0] BSR_C2_SPI_MASTER = 2'h1;
  localparam logic [1:0] BSR_C2_ROM = 2'h3;

  localparam int BSR_WD_W = 32;
  localparam int BSR_LOAD_W = 8;
  localparam logic [BSR_WD_W-1:0] BSR_WD_RESET = 32'hffffffff;

  // Reset pulse length for core and peripherals
  localparam int BSR_RST_PULSE_NS = 1000;
  localparam int BSR_CLK_NS = 100;
  localparam int BSR_RST_CYC = (BSR_RST_PULSE_NS + BSR_CLK_NS - 1) / BSR_CLK_NS;
  localparam logic [3:0] BSR_RST_CYC_W = 4'(BSR_RST_CYC);

endpackage

// ===== hw/bsr_boot_decode.sv
/*
 Decodes the boot select pins into a boot source.
 Assumes pins are stable while sampled; pure combinational.
*/
`timescale 1ns/100ps
module bsr_boot_decode (
  input wire logic small_pkg_i,
  input wire logic [2:0] sel3_i,
  input wire logic [1:0] sel2_i,
  output bsr_pkg::bsr_boot_t boot_o
);
  always_comb begin
    boot_o = bsr_pkg::BSR_BOOT_RESERVED;
    if (small_pkg_i) begin
      if (sel2_i == bsr_pkg::BSR_C2_SPI_SLAVE) begin
        boot_o = bsr_pkg::BSR_BOOT_SPI_SLAVE;
      end else if (sel2_i == bsr_pkg::BSR_C2_SPI_MASTER) begin
        boot_o = bsr_pkg::BSR_BOOT_SPI_MASTER;
      end else if (sel2_i == bsr_pkg::BSR_C2_ROM) begin
        boot_o = bsr_pkg::BSR_BOOT_ROM;
      end
    end else begin
      if (sel3_i == bsr_pkg::BSR_C3_SPI_SLAVE) begin
        boot_o = bsr_pkg::BSR_BOOT_SPI_SLAVE;
      end else if (sel3_i == bsr_pkg::BSR_C3_SPI_MASTER) begin
        boot_o = bsr_pkg::BSR_BOOT_SPI_MASTER;
      end else if (sel3_i == bsr_pkg::BSR_C3_PARALLEL) begin
        boot_o = bsr_pkg::BSR_BOOT_PARALLEL;
      end else if (sel3_i == bsr_pkg::BSR_C3_ROM) begin
        boot_o = bsr_pkg::BSR_BOOT_ROM;
      end
    end
  end
endmodule

// ===== hw/bsr_watchdog.sv
/*
 32-bit down-counting watchdog with load and enable; holds at zero on expiry.
 Assumes synchronous active-low reset on the system clock.
*/
`timescale 1ns/100ps
module bsr_watchdog (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic load_i,
  input wire logic [bsr_pkg::BSR_WD_W-1:0] load_val_i,
  input wire logic enable_i,
  output logic [bsr_pkg::BSR_WD_W-1:0] count_o,
  output logic expire_o
);
  logic [bsr_pkg::BSR_WD_W-1:0] cnt_q, cnt_d;
  logic en_q, en_d;
  logic exp_q, exp_d;

  always_comb begin
    cnt_d = cnt_q;
    en_d = enable_i;
    exp_d = 1'b0;
    if (load_i) begin
      cnt_d = load_val_i;
    end else if (en_q) begin
      if (cnt_q == '0) begin
        exp_d = 1'b1;
        en_d = 1'b0;
      end else begin
        cnt_d = cnt_q - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      cnt_q <= bsr_pkg::BSR_WD_RESET;
      en_q <= 1'b0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      en_q <= en_d;
      exp_q <= exp_d;
    end
  end

  assign count_o = cnt_q;
  assign expire_o = exp_q;
endmodule

// ===== hw/bsr_top.sv
/*
 Boot source selection, boot load sequencing and reset control.
 Assumes pins synchronous to the 10 MHz clock; loader engines sit outside.
*/
`timescale 1ns/100ps
module bsr_top (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic small_pkg_i,
  input wire logic [2:0] boot_source_select_3pin_i,
  input wire logic [1:0] boot_source_select_2pin_i,
  input wire logic load_done_i,
  input wire logic load_byte_valid_i,
  input wire logic [bsr_pkg::BSR_LOAD_W-1:0] load_byte_i,
  input wire logic reset_out_running_reset_in_i,
  output logic reset_out_running_reset_in_o,
  output logic reset_out_running_reset_in_oe_o,
  input wire logic wd_load_i,
  input wire logic [bsr_pkg::BSR_WD_W-1:0] wd_load_val_i,
  input wire logic wd_enable_i,
  output logic [bsr_pkg::BSR_WD_W-1:0] wd_count_o,
  output bsr_pkg::bsr_boot_t boot_source_o,
  output logic load_spi_slave_o,
  output logic load_spi_master_o,
  output logic load_parallel_o,
  output logic boot_error_o,
  output logic mem_we_o,
  output logic [bsr_pkg::BSR_LOAD_W-1:0] mem_wdata_o,
  output logic core_nrst_o,
  output logic periph_nrst_o,
  output logic pll_sdram_nrst_o,
  output logic run_from_rom_o
);
  bsr_pkg::bsr_state_t st_q, st_d;
  bsr_pkg::bsr_boot_t boot_q, boot_d, boot_dec;
  logic [3:0] rcnt_q, rcnt_d;
  logic we_q, we_d;
  logic [bsr_pkg::BSR_LOAD_W-1:0] wdata_q, wdata_d;
  logic pin_q, pin_d;
  logic wd_expire;
  logic ext_req;

  bsr_boot_decode u_dec (
    .small_pkg_i(small_pkg_i),
    .sel3_i(boot_source_select_3pin_i),
    .sel2_i(boot_source_select_2pin_i),
    .boot_o(boot_dec)
  );

  bsr_watchdog u_wd (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .load_i(wd_load_i),
    .load_val_i(wd_load_val_i),
    .enable_i(wd_enable_i),
    .count_o(wd_count_o),
    .expire_o(wd_expire)
  );

  // External request only while we are not driving the pin
  assign ext_req = !pin_q && reset_out_running_reset_in_i;

  always_comb begin
    st_d = st_q;
    boot_d = boot_q;
    rcnt_d = rcnt_q;
    we_d = 1'b0;
    wdata_d = wdata_q;
    pin_d = 1'b0;
    case (st_q)
      bsr_pkg::BSR_ST_SAMPLE: begin
        boot_d = boot_dec;
        if (boot_dec == bsr_pkg::BSR_BOOT_RESERVED) begin
          st_d = bsr_pkg::BSR_ST_HALT;
        end else if (boot_dec == bsr_pkg::BSR_BOOT_ROM) begin
          st_d = bsr_pkg::BSR_ST_RUN;
        end else begin
          st_d = bsr_pkg::BSR_ST_LOAD;
        end
      end
      bsr_pkg::BSR_ST_LOAD: begin
        if (load_byte_valid_i) begin
          we_d = 1'b1;
          wdata_d = load_byte_i;
        end
        if (load_done_i) begin
          st_d = bsr_pkg::BSR_ST_RUN;
        end
      end
      bsr_pkg::BSR_ST_RUN: begin
        if (wd_expire || ext_req) begin
          st_d = bsr_pkg::BSR_ST_RESET;
          rcnt_d = bsr_pkg::BSR_RST_CYC_W;
          pin_d = 1'b1;
        end
      end
      bsr_pkg::BSR_ST_RESET: begin
        pin_d = 1'b1;
        if (rcnt_q == 4'h1) begin
          st_d = bsr_pkg::BSR_ST_RUN;
          pin_d = 1'b0;
        end else begin
          rcnt_d = rcnt_q - 4'h1;
        end
      end
      bsr_pkg::BSR_ST_HALT: begin
        st_d = bsr_pkg::BSR_ST_HALT;
      end
      default: begin
        st_d = bsr_pkg::BSR_ST_HALT;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      st_q <= bsr_pkg::BSR_ST_SAMPLE;
      boot_q <= bsr_pkg::BSR_BOOT_RESERVED;
      rcnt_q <= 4'h0;
      we_q <= 1'b0;
      wdata_q <= 8'h00;
      pin_q <= 1'b0;
    end else begin
      st_q <= st_d;
      boot_q <= boot_d;
      rcnt_q <= rcnt_d;
      we_q <= we_d;
      wdata_q <= wdata_d;
      pin_q <= pin_d;
    end
  end

  assign boot_source_o = boot_q;
  assign load_spi_slave_o = (st_q == bsr_pkg::BSR_ST_LOAD) && (boot_q == bsr_pkg::BSR_BOOT_SPI_SLAVE);
  assign load_spi_master_o = (st_q == bsr_pkg::BSR_ST_LOAD) && (boot_q == bsr_pkg::BSR_BOOT_SPI_MASTER);
  assign load_parallel_o = (st_q == bsr_pkg::BSR_ST_LOAD) && (boot_q == bsr_pkg::BSR_BOOT_PARALLEL);
  assign boot_error_o = (st_q == bsr_pkg::BSR_ST_HALT);
  assign run_from_rom_o = (boot_q == bsr_pkg::BSR_BOOT_ROM) && (st_q == bsr_pkg::BSR_ST_RUN);
  assign mem_we_o = we_q;
  assign mem_wdata_o = wdata_q;
  // Core and peripherals held in reset until loaded and during resets
  assign core_nrst_o = (st_q == bsr_pkg::BSR_ST_RUN);
  assign periph_nrst_o = (st_q == bsr_pkg::BSR_ST_RUN);
  assign pll_sdram_nrst_o = nrst_i;
  assign reset_out_running_reset_in_o = 1'b1;
  assign reset_out_running_reset_in_oe_o = pin_q;
endmodule

// ===== tb/bsr_chk_assertions.sv
/* Checker on the ports of the boot select and reset block.
   Assumes it is bound into bsr_top and shares its clock and reset. */
`timescale 1ns/100ps
module bsr_chk (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic load_byte_valid_i,
  input wire logic [7:0] load_byte_i,
  input wire logic wd_load_i,
  input wire logic [31:0] wd_load_val_i,
  input wire logic wd_enable_i,
  input wire logic reset_out_running_reset_in_oe_o,
  input wire logic [31:0] wd_count_o,
  input wire bsr_pkg::bsr_boot_t boot_source_o,
  input wire logic mem_we_o,
  input wire logic [7:0] mem_wdata_o,
  input wire logic core_nrst_o,
  input wire logic periph_nrst_o,
  input wire logic pll_sdram_nrst_o,
  input wire logic run_from_rom_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  property p_pll; pll_sdram_nrst_o == nrst_i; endproperty
  a_pll: assert property (p_pll) else $error("pll reset moved");
  property p_per; core_nrst_o == periph_nrst_o; endproperty
  a_per: assert property (p_per) else $error("core and periph resets differ");
  property p_rom; run_from_rom_o == (core_nrst_o && boot_source_o == bsr_pkg::BSR_BOOT_ROM); endproperty
  a_rom: assert property (p_rom) else $error("rom run flag wrong");
  property p_hold; $past(nrst_i) && $past(nrst_i, 2) |-> $stable(boot_source_o); endproperty
  a_hold: assert property (p_hold) else $error("boot source changed");
  property p_we; mem_we_o |-> $past(load_byte_valid_i) && mem_wdata_o == $past(load_byte_i); endproperty
  a_we: assert property (p_we) else $error("memory write wrong");
  property p_ldv; $past(wd_load_i) && $past(nrst_i) |-> wd_count_o == $past(wd_load_val_i); endproperty
  a_ldv: assert property (p_ldv) else $error("watchdog load wrong");
  property p_hld; !$past(wd_enable_i, 2) && !$past(wd_load_i) && $past(nrst_i) |-> $stable(wd_count_o); endproperty
  a_hld: assert property (p_hld) else $error("watchdog moved while off");
  property p_rr; $fell(core_nrst_o) |-> reset_out_running_reset_in_oe_o ##9 !core_nrst_o ##1 core_nrst_o; endproperty
  a_rr: assert property (p_rr) else $error("running reset length wrong");
endmodule
bind bsr_top bsr_chk u_bsr_chk (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .load_byte_valid_i(load_byte_valid_i),
  .load_byte_i(load_byte_i), .wd_load_i(wd_load_i), .wd_load_val_i(wd_load_val_i), .wd_enable_i(wd_enable_i),
  .reset_out_running_reset_in_oe_o(reset_out_running_reset_in_oe_o), .wd_count_o(wd_count_o),
  .boot_source_o(boot_source_o), .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o), .core_nrst_o(core_nrst_o),
  .periph_nrst_o(periph_nrst_o), .pll_sdram_nrst_o(pll_sdram_nrst_o), .run_from_rom_o(run_from_rom_o));

// ===== tb/bsr_board.sv
/* Board loader model: four bytes, then done, while a load runs.
   Assumes the block's load levels and the 10 MHz clock. */
`timescale 1ns/100ps
module bsr_board (
  input wire logic clk_sys_i,
  input wire logic loading_i,
  output logic vld_o = 1'b0,
  output logic [7:0] byte_o = 8'h00,
  output logic done_o = 1'b0
);
  logic [2:0] n_q = 3'h0;
  wire go = loading_i && n_q < 3'h4;
  always @(posedge clk_sys_i) begin
    n_q <= loading_i ? n_q + 3'(go) : 3'h0;
    vld_o <= go;
    byte_o <= go ? 8'h10 + 8'(n_q) : ~byte_o;
    done_o <= loading_i && !go;
  end
endmodule

// ===== tb/tb.sv
/* Bench: boot codes, running reset and watchdog reset.
   Assumes bsr_board streams four bytes per load. */
`timescale 1ns/100ps
module tb;
  logic clk_sys_i = 1'b0, nrst_i = 1'b0, sm = 1'b0, rr = 1'b0, wl = 1'b0, wen = 1'b0;
  logic [2:0] c3 = 3'h0;
  logic [1:0] c2 = 2'h0;
  logic [31:0] wv = 32'h0, wc;
  logic done, vld, oe, ro, ls, lm, lp, err, mwe, cn, pn, pl, rom;
  logic [7:0] byt, md;
  bsr_pkg::bsr_boot_t bs;
  int err_count = 0, num_checks = 0, nb = 0;
  initial forever #50 clk_sys_i = ~clk_sys_i;
  bsr_board u_bsr_board (.clk_sys_i(clk_sys_i), .loading_i(ls | lm | lp), .vld_o(vld), .byte_o(byt), .done_o(done));
  bsr_top u_bsr_top (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .small_pkg_i(sm),
    .boot_source_select_3pin_i(c3), .boot_source_select_2pin_i(c2), .load_done_i(done),
    .load_byte_valid_i(vld), .load_byte_i(byt), .reset_out_running_reset_in_i(oe ? ro : rr),
    .reset_out_running_reset_in_o(ro), .reset_out_running_reset_in_oe_o(oe), .wd_load_i(wl),
    .wd_load_val_i(wv), .wd_enable_i(wen), .wd_count_o(wc), .boot_source_o(bs), .load_spi_slave_o(ls),
    .load_spi_master_o(lm), .load_parallel_o(lp), .boot_error_o(err), .mem_we_o(mwe),
    .mem_wdata_o(md), .core_nrst_o(cn), .periph_nrst_o(pn), .pll_sdram_nrst_o(pl), .run_from_rom_o(rom));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic test_done;
    $display("checks %0d, errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wt(input logic v);
    int i;
    for (i = 0; i < 200 && cn !== v; i++) @(negedge clk_sys_i);
    if (i == 200) begin
      chk(32'h0, 32'h1);
      test_done;
    end
  endtask
  always @(negedge clk_sys_i) if (mwe === 1'b1) begin
    chk(md, 32'h10 + nb);
    nb++;
  end
  task automatic boot(input logic s, input logic [2:0] a, input logic [1:0] b, input logic [2:0] e);
    nrst_i <= 1'b0;
    sm <= s;
    c3 <= a;
    c2 <= b;
    tick(16);
    nb = 0;
    nrst_i <= 1'b1;
    tick(3);
    chk(bs, e);
    chk({ls, lm, lp}, e == 3'h0 ? 3'h4 : e == 3'h1 ? 3'h2 : e == 3'h2 ? 3'h1 : 3'h0);
    if (e !== 3'h4) begin
      wt(1'b1);
      chk(nb, e == 3'h3 ? 0 : 4);
      chk(rom, e == 3'h3);
    end else begin
      tick(20);
      chk({cn, err}, 2'b01);
    end
    tick(1);
    c3 <= ~a;
    c2 <= ~b;
    tick(2);
    chk(bs, e);
  endtask
  task automatic rrun(input logic p);
    int n;
    nb = 0;
    if (p) begin
      rr <= 1'b1;
      tick(1);
      rr <= 1'b0;
    end else begin
      wv <= 32'h5;
      wl <= 1'b1;
      tick(1);
      wl <= 1'b0;
      tick(3);
      chk(wc, 32'h5);
      wen <= 1'b1;
    end
    wt(1'b0);
    chk({oe, ro, cn, pn, pl}, 5'b11001);
    for (n = 0; n < 50 && cn === 1'b0; n++) @(negedge clk_sys_i);
    chk(n, 10);
    chk({pn, pl, nb[7:0]}, 10'h300);
    chk(bs, 32'h2);
    tick(1);
    wen <= 1'b0;
  endtask
  initial begin
    for (int i = 0; i < 8; i++) boot(1'b0, 3'(i), 2'h3, i > 3 ? 3'h4 : 3'(i));
    for (int i = 0; i < 4; i++) boot(1'b1, 3'h7, 2'(i), i == 2 ? 3'h4 : 3'(i));
    boot(1'b0, 3'h2, 2'h0, 3'h2);
    rrun(1'b1);
    rrun(1'b0);
    test_done;
  end
endmodule
